//--- logic/dms_regs.vh
`ifndef DMS_REGS_VH
`define DMS_REGS_VH
// ----------------------------------------
// slave address and frame layout
// ----------------------------------------
`define DMS_ADDR7          7'h72
`define DMS_ADDR_WR        8'he4
`define DMS_ADDR_RD        8'he5
`define DMS_SPI_LEAD       5'd2
`define DMS_SPI_ADDR_END   5'd10
`define DMS_SPI_REG_END    5'd18
`define DMS_SPI_COMMIT     5'd26
`define DMS_BYTE_BITS      4'd8
`endif

//--- logic/dms_slave.v
`timescale 1ns/1ps
`include "dms_regs.vh"
module dms_slave (
    input  wire       clk,
    input  wire       reset,
    input  wire       sel_n,
    input  wire       scl,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        reg_write,
    output reg        reg_read,
    input  wire [7:0] reg_rdata
);
    // ----------------------------------------
    // input synchronisers and edge detection
    // ----------------------------------------
    wire [2:0] sync;
    reg  [2:0] prev;

    dms_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   ({sel_n, scl, sda_in}),
        .dout  (sync)
    );

    wire sel_s = sync[2];
    wire scl_s = sync[1];
    wire sda_s = sync[0];

    // previous synchronised levels
    always @(posedge clk) begin
        if (reset) begin
            prev <= 3'h7;
        end else begin
            prev <= sync;
        end
    end

    wire scl_rise = scl_s & ~prev[1];
    wire scl_fall = ~scl_s & prev[1];
    wire sel_fall = ~sel_s & prev[2];
    wire sda_move = sda_s ^ prev[0];
    // start and stop only while clock high, select high
    wire i2c_start = sel_s & scl_s & prev[1] & ~sda_s & prev[0];
    wire i2c_stop  = sel_s & scl_s & prev[1] & sda_s & ~prev[0];

    assign sda_out = 1'b0; // open drain, drive low only

    // ----------------------------------------
    // spi frame engine
    // ----------------------------------------
    reg       spi_act;
    reg [4:0] spi_cnt;
    reg [7:0] spi_sh;
    reg       spi_rd;
    reg [7:0] spi_out;
    reg       spi_oe;

    // data must hold until the first clock fall of a frame
    wire spi_early = (spi_cnt == 5'h00) || (spi_cnt == 5'h01 && scl_s);

    // spi receive, count and output shift
    always @(posedge clk) begin
        if (reset) begin
            spi_act <= 1'b0;
            spi_cnt <= 5'h00;
            spi_sh  <= 8'h00;
            spi_rd  <= 1'b0;
            spi_out <= 8'h00;
            spi_oe  <= 1'b0;
        end else if (sel_fall) begin
            spi_act <= 1'b1;
            spi_cnt <= 5'h00;
            spi_rd  <= 1'b0;
            spi_oe  <= 1'b0;
        end else if (sel_s) begin
            spi_act <= 1'b0;
            spi_oe  <= 1'b0;
        end else if (spi_act && sda_move && spi_early) begin
            spi_act <= 1'b0;
        end else if (spi_act && scl_rise) begin
            spi_cnt <= spi_cnt + 5'h01;
            if (spi_cnt >= `DMS_SPI_LEAD) begin
                spi_sh <= {spi_sh[6:0], sda_s};
            end
            if (spi_cnt == `DMS_SPI_ADDR_END - 5'd1) begin
                spi_rd <= sda_s;
                if ({spi_sh[6:0], sda_s} != `DMS_ADDR_WR &&
                    {spi_sh[6:0], sda_s} != `DMS_ADDR_RD) begin
                    spi_act <= 1'b0;
                end
            end
            if (spi_cnt == `DMS_SPI_COMMIT) begin
                spi_act <= 1'b0;
            end
        end else if (spi_act && scl_fall) begin
            if (spi_cnt == `DMS_SPI_REG_END && spi_rd) begin
                spi_out <= reg_rdata;
                spi_oe  <= ~reg_rdata[7];
            end else if (spi_cnt > `DMS_SPI_REG_END && spi_rd &&
                         spi_cnt < `DMS_SPI_COMMIT) begin
                spi_out <= {spi_out[6:0], 1'b0};
                spi_oe  <= ~spi_out[6];
            end else begin
                spi_oe  <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // i2c engine
    // ----------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_REG  = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_SEND = 3'd4;
    localparam ST_MACK = 3'd5;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] i2c_sh;
    reg       ack_phase;
    reg       i2c_oe;

    // byte shifting, ack and read serialisation
    always @(posedge clk) begin
        if (reset) begin
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            i2c_sh    <= 8'h00;
            ack_phase <= 1'b0;
            i2c_oe    <= 1'b0;
        end else if (!sel_s || i2c_stop) begin
            state     <= ST_IDLE;
            ack_phase <= 1'b0;
            i2c_oe    <= 1'b0;
        end else if (i2c_start) begin
            state     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
            i2c_oe    <= 1'b0;
        end else if (scl_rise && state != ST_IDLE) begin
            if (state == ST_MACK) begin
                // master ack continues, nack ends
                state <= sda_s ? ST_IDLE : ST_SEND;
            end else if (!ack_phase && state != ST_SEND) begin
                i2c_sh  <= {i2c_sh[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (state == ST_SEND && !ack_phase) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end else if (scl_fall && state != ST_IDLE) begin
            if (ack_phase) begin
                ack_phase <= 1'b0;
                bit_cnt   <= 4'h0;
                if (state == ST_SEND) begin
                    i2c_oe <= ~reg_rdata[7];
                    i2c_sh <= reg_rdata;
                end else begin
                    i2c_oe <= 1'b0;
                end
            end else if (bit_cnt == `DMS_BYTE_BITS) begin
                case (state)
                    ST_ADDR: begin
                        if (i2c_sh[7:1] == `DMS_ADDR7) begin
                            ack_phase <= 1'b1;
                            i2c_oe    <= 1'b1;
                            state     <= i2c_sh[0] ? ST_SEND : ST_REG;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_REG: begin
                        ack_phase <= 1'b1;
                        i2c_oe    <= 1'b1;
                        state     <= ST_DATA;
                    end
                    ST_DATA: begin
                        ack_phase <= 1'b1;
                        i2c_oe    <= 1'b1;
                    end
                    ST_SEND: begin
                        i2c_oe  <= 1'b0;
                        state   <= ST_MACK;
                        bit_cnt <= 4'h0;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end else if (state == ST_SEND) begin
                i2c_oe <= ~i2c_sh[6];
                i2c_sh <= {i2c_sh[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // register port and pin enable
    // ----------------------------------------
    wire i2c_byte = scl_fall && !ack_phase && bit_cnt == `DMS_BYTE_BITS;
    wire send_load = scl_fall && ack_phase && state == ST_SEND;

    // address capture, write commit and read strobes
    always @(posedge clk) begin
        if (reset) begin
            reg_addr  <= 8'h00;
            reg_wdata <= 8'h00;
            reg_write <= 1'b0;
            reg_read  <= 1'b0;
            sda_oe    <= 1'b0;
        end else begin
            reg_write <= 1'b0;
            reg_read  <= 1'b0;
            sda_oe    <= spi_oe | i2c_oe;
            if (spi_act && !sel_s && scl_rise) begin
                if (spi_cnt == `DMS_SPI_REG_END - 5'd1) begin
                    reg_addr <= {spi_sh[6:0], sda_s};
                end
                if (spi_cnt == `DMS_SPI_COMMIT - 5'd1 && !spi_rd) begin
                    reg_wdata <= {spi_sh[6:0], sda_s};
                    reg_write <= 1'b1;
                end
            end
            if (spi_act && !sel_s && scl_fall && spi_rd &&
                spi_cnt == `DMS_SPI_REG_END) begin
                reg_read <= 1'b1;
            end
            if (i2c_byte && state == ST_REG) begin
                reg_addr <= i2c_sh;
            end
            if (i2c_byte && state == ST_DATA) begin
                reg_wdata <= i2c_sh;
                reg_write <= 1'b1;
            end
            if (send_load) begin
                reg_read <= 1'b1;
            end
            if (scl_rise && state == ST_MACK && !sda_s) begin
                reg_addr <= reg_addr + 8'h01;
            end
        end
    end
endmodule

//--- logic/dms_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// two flop synchroniser
// ----------------------------------------
module dms_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    // first stage read only by second stage
    always @(posedge clk) begin
        if (reset) begin
            meta <= {WIDTH{1'b1}};
            dout <= {WIDTH{1'b1}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

//--- tb/dms_host.sv
`timescale 1ns/1ps
// -----------------
// serial host model
// -----------------
module dms_host (
    input  wire sda,
    output reg  sel_n,
    output reg  scl,
    output reg  sda_low
);
    localparam real H = 62.5;
    // idle bus: both lines high
    initial {sel_n, scl, sda_low} = 3'b110;
    // one bit: move data while clock low, sample at rise
    task bit_io(input v, output b);
        begin
            #20 sda_low <= !v;
            #(H-20) scl <= 1'b1;
            #1 b = sda;
            #(H-1) scl <= 1'b0;
        end
    endtask
    // nine clock pulses per byte, ninth for the acknowledge
    task xfer(input [8:0] v, output [8:0] q);
        integer i;
        begin
            for (i = 8; i >= 0; i = i - 1)
                bit_io(v[i], q[i]);
        end
    endtask
    task start;
        begin
            sda_low <= 1'b1;
            #H scl <= 1'b0;
        end
    endtask
    task stop;
        begin
            #20 sda_low <= 1'b1;
            #H scl <= 1'b1;
            #H sda_low <= 1'b0;
            #H;
        end
    endtask
    // spi frame; n rising edges, 27 is a whole frame
    task spi(input [7:0] a, input [7:0] r, input [7:0] d,
             input [4:0] n, output [7:0] q);
        reg [26:0] f;
        reg        b;
        integer    i;
        begin
            f = {2'b10, a, r, d, 1'b1};
            scl <= 1'b0;
            #20 sel_n <= 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                #20 sda_low <= !f[26-i] && !(a[0] && i >= 18);
                #(H-20) scl <= 1'b1;
                #1 b = sda;
                if (i < 26)
                    q = {q[6:0], b};
                #(H-1) if (i < n - 1) scl <= 1'b0;
            end
            sda_low <= 1'b0;
            #H sel_n <= 1'b1;
            #625;
        end
    endtask
endmodule

//--- tb/dms_slave_properties.sv
`timescale 1ns/1ps
// ------------
// port checker
// ------------
module dms_slave_chk (
    input wire       clk,
    input wire       reset,
    input wire       sel_n,
    input wire       scl,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_rdata
);
    reg [4:0] rises;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // scl rises seen inside a frame
    always @(posedge clk) begin
        if (reset || sel_n)
            rises <= 5'h0;
        else if ($rose(scl))
            rises <= rises + 5'h1;
    end
    spi_commit_a: assert property (
        !sel_n && reg_write |-> rises == 5'd26)
        else $error("spi write off edge 26");
    spi_no_ack_a: assert property (!sel_n && rises < 5'd18 |-> !sda_oe)
        else $error("spi drive before turn");
    spi_turn_a: assert property (!sel_n && reg_read |-> rises == 5'd18)
        else $error("spi read start off");
    oe_change_a: assert property (
        $changed(sda_oe) && rises < 5'd26 |-> !scl)
        else $error("data moved with clock high");
    oe_hold_a: assert property ($rose(scl) |=> $stable(sda_oe) [*3])
        else $error("data unstable in clock high");
    wr_pulse_a: assert property (reg_write |=> !reg_write)
        else $error("write pulse too long");
    wr_rd_a: assert property (!(reg_write && reg_read))
        else $error("read and write together");
    early_drop_a: assert property (
        $rose(sel_n) && rises < 5'd26 |-> !reg_write [*6])
        else $error("write after early release");
    pin_low_a: assert property (!sda_out)
        else $error("data pin driven high");
    addr_hold_a: assert property (
        reg_write || reg_read |-> $stable(reg_addr))
        else $error("address moved at access");
    cover property (!sel_n && reg_write);
    cover property (sel_n && scl && $fell(sda_in));
    cover property (sel_n && $rose(sda_oe));
    cover property ($rose(sel_n) && rises < 5'd26);
endmodule

bind dms_slave dms_slave_chk u_chk (.clk(clk), .reset(reset), .sel_n(sel_n),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));

//--- tb/dms_slave_tb.sv
`timescale 1ns/1ps
module dms_slave_tb;
    reg        clk, reset;
    reg  [7:0] mem [0:255];
    reg  [7:0] q;
    reg  [8:0] r;
    wire       sel_n, scl, sda_low, sda_out, sda_oe, reg_write, reg_read;
    wire [7:0] reg_addr, reg_wdata;
    wire       sda = !(sda_low || (sda_oe && !sda_out));
    integer    n_mismatch, total_checks, i;
    dms_host host (.sda(sda), .sel_n(sel_n), .scl(scl), .sda_low(sda_low));
    dms_slave DUT (.clk(clk), .reset(reset), .sel_n(sel_n), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(mem[reg_addr]));
    // register store behind the port
    always @(posedge clk) begin
        if (reg_write)
            mem[reg_addr] <= reg_wdata;
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task t_spi;
        begin
            host.spi(8'he4, 8'h10, 8'h55, 5'd27, q);
            check(mem[8'h10], 8'h55);
            host.spi(8'he4, 8'h11, 8'haa, 5'd25, q);
            check(mem[8'h11], 8'h00);
            host.spi(8'he6, 8'h12, 8'h77, 5'd27, q);
            check(mem[8'h12], 8'h00);
            host.spi(8'he5, 8'h13, 8'h00, 5'd27, q);
            check(q, 8'ha5);
            check(reg_addr, 8'h13);
            check(mem[8'h13], 8'ha5);
        end
    endtask
    task t_i2c;
        begin
            host.start;
            host.xfer({8'he4, 1'b1}, r);
            check({7'h0, r[0]}, 8'h00);
            host.xfer({8'h14, 1'b1}, r);
            host.xfer({8'h3c, 1'b1}, r);
            host.stop;
            check(mem[8'h14], 8'h3c);
            host.start;
            host.xfer({8'he6, 1'b1}, r);
            check({7'h0, r[0]}, 8'h01);
            host.stop;
            host.start;
            host.xfer({8'he5, 1'b1}, r);
            host.xfer(9'h1ff, r);
            check(r[8:1], 8'h3c);
            check({7'h0, r[0]}, 8'h01);
            host.stop;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        summarize;
    end
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        reset = 1'b1;
        for (i = 0; i < 256; i = i + 1)
            mem[i] = 8'h00;
        mem[8'h13] = 8'ha5;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_spi;
        t_i2c;
        summarize;
    end
endmodule
